// File: csc_config_target.sv
// Serial configuration receiver of a target device in a cascaded chain
// Behaviour
// - Any error stops whole chain; restart by reload request or auto restart
// - Master reset pulls status low, resetting targets
// - Shared lines give common finish and restart
// - User mode 299 init clocks after load_complete
// - Init clock internal or user start clock
// - Reset while reload request or status low
// - One data bit per rising serial clock edge
// - Data error pulls status flag low
// - Auto restart releases status within 40 us
module csc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : csc_sync

module csc_config_target (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       RELOAD_REQUEST_N,
  input  wire logic       STATUS_FLAG_N_IN,
  output logic            STATUS_FLAG_N_OUT,
  output logic            STATUS_FLAG_N_OE_N,
  input  wire logic       LOAD_COMPLETE_IN,
  output logic            LOAD_COMPLETE_OUT,
  output logic            LOAD_COMPLETE_OE_N,
  input  wire logic       CONFIG_CLOCK,
  input  wire logic       CONFIG_DATA,
  input  wire logic       USER_START_CLOCK,
  input  wire logic       USE_USER_CLOCK,
  input  wire logic       AUTO_RESTART,
  output logic [7:0]      WORD_DATA,
  output logic            WORD_VALID,
  input  wire logic       WORD_READY,
  output logic            USER_MODE,
  output logic            IN_RESET
);
  logic [csc_pkg::SYNC_W-1:0] sy;
  csc_pkg::csc_state_t        state;
  csc_pkg::csc_state_t        next_state;
  logic [15:0]                bit_cnt;
  logic [15:0]                next_bit_cnt;
  logic [7:0]                 shift;
  logic [7:0]                 next_shift;
  logic [8:0]                 init_cnt;
  logic [8:0]                 next_init_cnt;
  logic [10:0]                tmo_cnt;
  logic [10:0]                next_tmo_cnt;
  logic                       clk_prev;
  logic                       user_prev;
  logic                       clk_rise;
  logic                       user_rise;
  logic                       init_tick;
  logic                       reset_req;
  logic                       push;
  logic [7:0]                 push_word;
  logic                       in_ready;
  logic [7:0]                 mem [2];
  logic [7:0]                 next_mem [2];
  logic                       wr_ptr;
  logic                       next_wr_ptr;
  logic                       rd_ptr;
  logic                       next_rd_ptr;
  logic [1:0]                 fill;
  logic [1:0]                 next_fill;
  logic                       pop;

  // Straps and link pins come from other domains
  csc_sync #(.W(csc_pkg::SYNC_W)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .d     ({AUTO_RESTART, USE_USER_CLOCK, USER_START_CLOCK,
             LOAD_COMPLETE_IN, STATUS_FLAG_N_IN, RELOAD_REQUEST_N,
             CONFIG_DATA, CONFIG_CLOCK}),
    .q     (sy)
  );

  assign clk_rise  = sy[csc_pkg::SY_CLK] & ~clk_prev;
  assign user_rise = sy[csc_pkg::SY_USER_CLK] & ~user_prev;
  // Internal oscillator stands in as one tick per system clock
  assign init_tick = sy[csc_pkg::SY_USE_USER] ? user_rise : 1'b1;
  assign reset_req = ~sy[csc_pkg::SY_RELOAD] | ~sy[csc_pkg::SY_STATUS];
  assign in_ready  = (fill != csc_pkg::BUF_DEPTH);

  always_comb
  begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_init_cnt = init_cnt;
    next_tmo_cnt  = tmo_cnt;
    push          = 1'b0;
    push_word     = {shift[6:0], sy[csc_pkg::SY_DATA]};
    if (state != csc_pkg::ST_ERROR && reset_req)
    begin
      next_state    = csc_pkg::ST_RESET;
      next_bit_cnt  = 16'h0000;
      next_init_cnt = 9'h000;
    end
    else
    begin
      unique case (state)
        csc_pkg::ST_RESET:
        begin
          next_bit_cnt  = 16'h0000;
          next_init_cnt = 9'h000;
          next_state    = csc_pkg::ST_CONFIG;
        end
        csc_pkg::ST_CONFIG:
        begin
          if (clk_rise)
          begin
            next_shift   = push_word;
            next_bit_cnt = bit_cnt + 16'h0001;
            if (bit_cnt[2:0] == csc_pkg::WORD_LAST_BIT)
            begin
              // The serial clock cannot be stalled, so overflow is an error
              push = in_ready;
              if (!in_ready)
              begin
                next_state   = csc_pkg::ST_ERROR;
                next_tmo_cnt = 11'h000;
              end
              else if (bit_cnt == csc_pkg::STREAM_LAST)
              begin
                next_state = csc_pkg::ST_INIT;
              end
            end
          end
        end
        csc_pkg::ST_INIT:
        begin
          // Wait for the shared line, so the whole chain starts together
          if (sy[csc_pkg::SY_LOAD] && init_tick)
          begin
            next_init_cnt = init_cnt + 9'h001;
            if (init_cnt == csc_pkg::INIT_LAST)
            begin
              next_state = csc_pkg::ST_USER;
            end
          end
        end
        csc_pkg::ST_USER:
        begin
          next_state = csc_pkg::ST_USER;
        end
        csc_pkg::ST_ERROR:
        begin
          next_tmo_cnt = tmo_cnt + 11'h001;
          if (!sy[csc_pkg::SY_RELOAD])
          begin
            next_state = csc_pkg::ST_RESET;
          end
          else if (sy[csc_pkg::SY_AUTO] &&
                   tmo_cnt == csc_pkg::RESTART_LAST)
          begin
            next_state = csc_pkg::ST_RESET;
          end
        end
        default:
        begin
          next_state = csc_pkg::ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state     <= csc_pkg::ST_RESET;
      bit_cnt   <= 16'h0000;
      shift     <= 8'h00;
      init_cnt  <= 9'h000;
      tmo_cnt   <= 11'h000;
      clk_prev  <= 1'b0;
      user_prev <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      init_cnt  <= next_init_cnt;
      tmo_cnt   <= next_tmo_cnt;
      clk_prev  <= sy[csc_pkg::SY_CLK];
      user_prev <= sy[csc_pkg::SY_USER_CLK];
    end
  end

  // Two-entry word buffer towards the fabric
  assign pop = WORD_VALID & WORD_READY;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (push)
    begin
      next_mem[wr_ptr] = push_word;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop)
    begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop)
    begin
      next_fill = fill + 2'h1;
    end
    else if (pop && !push)
    begin
      next_fill = fill - 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end
    else
    begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  assign WORD_DATA  = mem[rd_ptr];
  assign WORD_VALID = (fill != 2'h0);

  // Open-drain lines: only ever driven low
  assign STATUS_FLAG_N_OUT  = 1'b0;
  assign STATUS_FLAG_N_OE_N = ~((state == csc_pkg::ST_ERROR) ||
                                (state == csc_pkg::ST_RESET &&
                                 !sy[csc_pkg::SY_RELOAD]));
  assign LOAD_COMPLETE_OUT  = 1'b0;
  assign LOAD_COMPLETE_OE_N = ~((state == csc_pkg::ST_RESET) ||
                                (state == csc_pkg::ST_CONFIG) ||
                                (state == csc_pkg::ST_ERROR));
  assign USER_MODE = (state == csc_pkg::ST_USER);
  assign IN_RESET  = (state == csc_pkg::ST_RESET) ||
                     (state == csc_pkg::ST_ERROR);

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_user_after_init: assert property ($rose(USER_MODE) |->
    $past(init_cnt) == csc_pkg::INIT_LAST)
    else $error("user mode entered at wrong init count");
  a_init_source: assert property (state == csc_pkg::ST_INIT &&
    sy[csc_pkg::SY_USE_USER] && !user_rise && !reset_req |=>
    init_cnt == $past(init_cnt))
    else $error("init count moved without user clock edge");
  a_reset_hold: assert property (!sy[csc_pkg::SY_RELOAD] |=>
    state == csc_pkg::ST_RESET)
    else $error("not in reset while reload requested");
  a_chain_reset: assert property (state != csc_pkg::ST_ERROR &&
    !sy[csc_pkg::SY_STATUS] |=> state == csc_pkg::ST_RESET)
    else $error("status low did not reset device");
  a_bit_shift: assert property (clk_rise && state == csc_pkg::ST_CONFIG &&
    !reset_req |=> bit_cnt == $past(bit_cnt) + 16'h0001)
    else $error("serial bit not counted");
  a_overflow_err: assert property (
    state == csc_pkg::ST_CONFIG && clk_rise && !reset_req &&
    bit_cnt[2:0] == csc_pkg::WORD_LAST_BIT && !in_ready |=>
    state == csc_pkg::ST_ERROR ##1 !STATUS_FLAG_N_OE_N)
    else $error("overflow did not flag error");
  a_restart_bound: assert property (state == csc_pkg::ST_ERROR &&
    sy[csc_pkg::SY_AUTO] |-> tmo_cnt <= csc_pkg::RESTART_LAST)
    else $error("status held beyond restart timeout");
  a_load_low_cfg: assert property (state == csc_pkg::ST_CONFIG |->
    !LOAD_COMPLETE_OE_N && $past(state) != csc_pkg::ST_USER)
    else $error("load complete released during configuration");
  a_mixed_start: assert property (state == csc_pkg::ST_INIT &&
    !sy[csc_pkg::SY_LOAD] && !reset_req |=>
    init_cnt == $past(init_cnt))
    else $error("init advanced before shared line high");

  c_user_mode: cover property ($rose(USER_MODE));
  c_overflow: cover property ($rose(state == csc_pkg::ST_ERROR));
  c_auto_restart: cover property (state == csc_pkg::ST_ERROR ##1
    state == csc_pkg::ST_RESET);
  c_buffer_full: cover property (fill == csc_pkg::BUF_DEPTH);
endmodule : csc_config_target

// File: csc_config_target_tb.sv
// Self-checking bench for the serial configuration target
module csc_config_target_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reload_n = 1'b1;
  logic        use_user = 1'b0;
  logic        user_clk = 1'b0;
  logic        uclk_on = 1'b0;
  logic        ready = 1'b0;
  logic [63:0] image = 64'h0;
  logic [31:0] seed = 32'h05a44890;
  logic        st_out, st_oe_n, ld_out, ld_oe_n, dclk, data, oe_reset_n;
  logic [7:0]  word;
  logic        valid, user_mode, in_reset;
  logic        status_line, load_line;
  logic [7:0]  exp_q[$];
  bit          cmp_on = 1'b0;
  bit          rnd_ready = 1'b0;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          cnt;
  // Open-drain lines with board pull-ups
  assign status_line = (st_oe_n ? 1'b1 : st_out) & oe_reset_n;
  assign load_line = ld_oe_n ? 1'b1 : ld_out;
  csc_config_target dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .RELOAD_REQUEST_N(reload_n), .STATUS_FLAG_N_IN(status_line),
    .STATUS_FLAG_N_OUT(st_out), .STATUS_FLAG_N_OE_N(st_oe_n),
    .LOAD_COMPLETE_IN(load_line), .LOAD_COMPLETE_OUT(ld_out),
    .LOAD_COMPLETE_OE_N(ld_oe_n), .CONFIG_CLOCK(dclk),
    .CONFIG_DATA(data), .USER_START_CLOCK(user_clk),
    .USE_USER_CLOCK(use_user), .AUTO_RESTART(1'b1), .WORD_DATA(word),
    .WORD_VALID(valid), .WORD_READY(ready), .USER_MODE(user_mode),
    .IN_RESET(in_reset));
  csc_mem_chain_model mem_u (.clk(sys_clk), .status_line(status_line),
    .load_line(load_line), .image(image), .dclk(dclk), .data(data),
    .oe_reset_n(oe_reset_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks_done++;
    if (seen !== expd)
    begin
      err_count++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, expd);
    end
  endtask : check
  task automatic final_report();
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  always #10 sys_clk = ~sys_clk;
  always #80 user_clk = uclk_on ? ~user_clk : 1'b0;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (rnd_ready)
    begin
      seed <= xs(seed);
      ready <= seed[3];
    end
    if (cmp_on && valid === 1'b1 && ready === 1'b1 && exp_q.size() > 0)
      check(word, exp_q.pop_front());
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic configure(input logic user);
    use_user <= user;
    image = {xs(seed), xs(xs(seed))};
    for (int i = 0; i < 8; i++)
      exp_q.push_back(image[63-8*i -: 8]);
    cmp_on = 1'b1;
    mem_u.send(64);
    check(load_line, 1'b1);
    if (!user)
    begin
      repeat (csc_pkg::INIT_CYCLES - 25) @(posedge sys_clk);
      check(user_mode, 1'b0);
      repeat (30) @(posedge sys_clk);
      check(user_mode, 1'b1);
    end
    else
    begin
      repeat (350) @(posedge sys_clk);
      check(user_mode, 1'b0);
      uclk_on = 1'b1;
      for (cnt = 0; cnt < 400 && user_mode !== 1'b1; cnt++)
        @(posedge user_clk) #120;
      check(cnt, csc_pkg::INIT_CYCLES);
      uclk_on = 1'b0;
    end
    for (cnt = 0; cnt < 200 && exp_q.size() > 0; cnt++)
      @(posedge sys_clk);
    check(exp_q.size(), 0);
    cmp_on = 1'b0;
  endtask : configure
  task automatic reload_pulse();
    reload_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(in_reset, 1'b1);
    check(user_mode, 1'b0);
    reload_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask : reload_pulse
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rnd_ready = 1'b1;
    configure(1'b0);
    reload_pulse();
    configure(1'b1);
    // Short stream: master sees no load_complete and resets the chain
    reload_pulse();
    fork
      mem_u.send(40);
      begin
        wait (oe_reset_n === 1'b0);
        repeat (4) @(posedge sys_clk);
        check(in_reset, 1'b1);
        check(ld_oe_n, 1'b0);
      end
    join
    exp_q.delete();
    configure(1'b0);
    // Consumer stalls: third byte overflows the two-entry buffer
    reload_pulse();
    rnd_ready = 1'b0;
    ready <= 1'b0;
    image = ~image;
    fork
      mem_u.send(64);
      begin
        for (cnt = 0; cnt < 3000 && st_oe_n !== 1'b0; cnt++)
          @(posedge sys_clk);
        #1 check(in_reset, 1'b1);
        for (cnt = 0; cnt < 3000 && st_oe_n === 1'b0; cnt++)
          @(posedge sys_clk);
        check(cnt <= csc_pkg::RESTART_CYCLES + 4, 1'b1);
        ready <= 1'b1;
      end
    join
    check(load_line, 1'b1);
    final_report();
  end
endmodule : csc_config_target_tb

// File: csc_mem_chain_model.sv
// Behavioural pair of cascaded serial configuration memories
module csc_mem_chain_model (
  input  wire logic        clk,
  input  wire logic        status_line,
  input  wire logic        load_line,
  input  wire logic [63:0] image,
  output logic             dclk,
  output logic             data,
  output logic             oe_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic casc0_n = 1'b1;
  initial
  begin
    dclk = 1'b0;
    data = 1'b0;
    oe_reset_n = 1'b1;
  end
  // First memory holds the upper half, the second the lower half
  task automatic send(input int nbits);
    bit ok;
    ok = 1'b0;
    while (!ok)
    begin
      wait (status_line === 1'b1 && load_line === 1'b0);
      @(posedge clk);
      ok = 1'b1;
      for (int i = 0; i < nbits; i++)
      begin
        if (status_line !== 1'b1)
        begin
          ok = 1'b0;
          break;
        end
        casc0_n <= (i < 32) ? 1'b1 : 1'b0;
        data <= image[63-i];
        repeat (4) @(posedge clk);
        dclk <= 1'b1;
        repeat (4) @(posedge clk);
        dclk <= 1'b0;
      end
      // Released line has no pull, so it shows a changed level
      data <= ~data;
      casc0_n <= 1'b1;
      repeat (20) @(posedge clk);
      if (ok && load_line !== 1'b1)
      begin
        oe_reset_n <= 1'b0;
        repeat (40) @(posedge clk);
        oe_reset_n <= 1'b1;
      end
    end
  endtask : send
endmodule : csc_mem_chain_model

// File: csc_pkg.sv
// Constants and types for the serial configuration target
package csc_pkg;
  localparam int         CLK_PERIOD_NS      = 20;
  localparam int         RESTART_TIMEOUT_NS = 40000;
  // Longest time, so the count rounds down
  localparam int         RESTART_CYCLES     = RESTART_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [10:0] RESTART_LAST      = 11'(RESTART_CYCLES - 1);
  localparam int         INIT_CYCLES        = 299;
  localparam logic [8:0] INIT_LAST          = 9'(INIT_CYCLES - 1);
  localparam int         WORD_BITS          = 8;
  localparam logic [2:0] WORD_LAST_BIT      = 3'h7;
  localparam int         STREAM_BITS        = 64;
  localparam logic [15:0] STREAM_LAST       = 16'(STREAM_BITS - 1);
  localparam logic [1:0] BUF_DEPTH          = 2'h2;
  localparam int         SYNC_W             = 8;
  localparam int         SY_CLK             = 0;
  localparam int         SY_DATA            = 1;
  localparam int         SY_RELOAD          = 2;
  localparam int         SY_STATUS          = 3;
  localparam int         SY_LOAD            = 4;
  localparam int         SY_USER_CLK        = 5;
  localparam int         SY_USE_USER        = 6;
  localparam int         SY_AUTO            = 7;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_CONFIG,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } csc_state_t;
endpackage : csc_pkg
